// ---- iah_map.svh ----
// Purpose: Constants for the asynchronous host slave port
// Assumes: 20 MHz core clock
// Notes:   Offsets, counts and reset values
`ifndef IAH_MAP_SVH
`define IAH_MAP_SVH
`define IAH_BASE_RST    12'h030
`define IAH_WAIT_CYC    4'h3
`define IAH_ADDR_HI     15
`define IAH_ADDR_LO     4
`define IAH_DMA_DEPTH   16
`define IAH_LOCAL_BUS_CLOCK_DIV    4'h3
`define IAH_RDY_LAG     4'h8
`define IAH_HOLD_CYC    4'h5
`endif

// ---- iah_pkg.sv ----
// Purpose: Types for the asynchronous host slave port
// Assumes: Nothing
// Notes:   Constants live in iah_map.svh
package iah_pkg;
  typedef enum logic [3:0] {
    IAH_IDLE  = 4'b0001,
    IAH_WAIT  = 4'b0010,
    IAH_DONE  = 4'b0100,
    IAH_HOLD  = 4'b1000
  } iah_state_t;
  typedef logic [31:0] iah_word_t;
endpackage

// ---- iah_if.sv ----
// Purpose: Pins between host bus controller and device port
// Assumes: Data pins are two-way, resolved here
// Notes:   No clocking block
`timescale 1ns/1ns
`default_nettype none
interface iah_if;
  logic [15:1] addr;
  logic        io_decode_qualifier;
  logic        async_read_strobe_n;
  logic        async_write_strobe_n;
  logic        byte_lane0_enable_n;
  logic        byte_lane1_enable_n;
  logic        byte_lane2_enable_n;
  logic        byte_lane3_enable_n;
  logic        async_ready_out;
  logic        local_decode_hit_n;
  logic        local_bus_clock;
  logic        address_strobe_n;
  logic        cycle_qualifier_n;
  logic        write_not_read_dir;
  logic        ready_return_n;
  logic        dma_ack_n;
  logic        exrdy;
  logic [31:0] dev_d_o;
  logic [3:0]  dev_d_oe;
  logic [31:0] host_d_o;
  logic [3:0]  host_d_oe;
  logic [31:0] d;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      d[i*8 +: 8] = dev_d_oe[i] ? dev_d_o[i*8 +: 8] :
                    host_d_oe[i] ? host_d_o[i*8 +: 8] : 8'hff;
    end
  end
  modport dev (
    input  addr, io_decode_qualifier, async_read_strobe_n, async_write_strobe_n,
    input  byte_lane0_enable_n, byte_lane1_enable_n, byte_lane2_enable_n,
    input  byte_lane3_enable_n, local_bus_clock, address_strobe_n, cycle_qualifier_n,
    input  write_not_read_dir, ready_return_n, dma_ack_n, exrdy, d,
    output async_ready_out, local_decode_hit_n, dev_d_o, dev_d_oe
  );
  modport host (
    output addr, io_decode_qualifier, async_read_strobe_n, async_write_strobe_n,
    output byte_lane0_enable_n, byte_lane1_enable_n, byte_lane2_enable_n,
    output byte_lane3_enable_n, local_bus_clock, address_strobe_n, cycle_qualifier_n,
    output write_not_read_dir, ready_return_n, dma_ack_n, exrdy, host_d_o, host_d_oe,
    input  async_ready_out, local_decode_hit_n, d
  );
endinterface
`default_nettype wire

// ---- iah_host.sv ----
// Purpose: Host bus controller end: ISA style I/O cycles and EISA DMA bursts
// Assumes: Requests held until o_done
// Notes:   Makes the link clock by dividing the core clock
`timescale 1ns/1ns
`default_nettype none
`include "iah_map.svh"
module iah_host
  import iah_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_req,
  input  wire logic        i_wr,
  input  wire logic        i_mode32,
  input  wire logic        i_dma,
  input  wire logic [15:1] i_addr,
  input  wire logic [3:0]  i_be_n,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_mem_wait,
  output logic             o_done,
  output logic [31:0]      o_rdata,
  output logic             o_hit,
  iah_if.host              bus
);
  logic [3:0]  div_r;
  logic        local_bus_clock_r;
  logic [2:0]  rdy_s_r;
  logic [2:0]  hit_s_r;
  logic        rdy_r;
  logic [2:0]  step_r;
  logic        act_r;
  logic [15:1] addr_r;
  logic [3:0]  be_r;
  logic        rd_r;
  logic        wr_r;
  logic        dack_r;
  logic [31:0] wd_r;
  logic        doe_r;
  logic        exrdy_r;
  logic [3:0]  tick_r;

  // Link clock from a divider, pacing DMA bursts
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_r  <= 4'h0;
      local_bus_clock_r <= 1'b0;
    end else if (div_r == `IAH_LOCAL_BUS_CLOCK_DIV) begin
      div_r  <= 4'h0;
      local_bus_clock_r <= ~local_bus_clock_r;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // Three stage sampling of pins from the device
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdy_s_r <= 3'h7;
      hit_s_r <= 3'h7;
      rdy_r   <= 1'b1;
      o_hit   <= 1'b0;
    end else begin
      rdy_s_r <= {rdy_s_r[1:0], bus.async_ready_out};
      hit_s_r <= {hit_s_r[1:0], bus.local_decode_hit_n};
      if (rdy_s_r[1] == rdy_s_r[2]) rdy_r <= rdy_s_r[2];
      if (hit_s_r[1] == hit_s_r[2]) o_hit <= ~hit_s_r[2];
    end
  end

  // Address before strobe, strobe held until ready, data taken at strobe end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      step_r  <= 3'h0;
      tick_r  <= 4'h0;
      act_r   <= 1'b0;
      addr_r  <= 15'h0;
      be_r    <= 4'hf;
      rd_r    <= 1'b1;
      wr_r    <= 1'b1;
      dack_r  <= 1'b1;
      wd_r    <= 32'h0;
      doe_r   <= 1'b0;
      o_done  <= 1'b0;
      o_rdata <= 32'h0;
    end else begin
      o_done <= 1'b0;
      if (!act_r && i_req && !o_done) begin
        act_r  <= 1'b1;
        step_r <= 3'h0;
        addr_r <= i_addr;
        be_r   <= i_be_n;
        wd_r   <= i_wdata;
        doe_r  <= i_wr;
      end else if (act_r && i_dma) begin
        // One word lined up at a link clock fall, held through the next rise
        dack_r <= 1'b0;
        case (step_r)
          3'h0: if (!i_mem_wait && div_r == `IAH_LOCAL_BUS_CLOCK_DIV && local_bus_clock_r) step_r <= 3'h1;
          3'h1: if (div_r == `IAH_LOCAL_BUS_CLOCK_DIV && local_bus_clock_r) step_r <= 3'h2;
          default: if (div_r == `IAH_LOCAL_BUS_CLOCK_DIV && !local_bus_clock_r) begin
            dack_r  <= 1'b1;
            doe_r   <= 1'b0;
            act_r   <= 1'b0;
            o_done  <= 1'b1;
            o_rdata <= bus.d;
          end
        endcase
      end else if (act_r) begin
        case (step_r)
          3'h0: begin
            step_r <= 3'h1;
            tick_r <= 4'h0;
            rd_r   <= i_wr;
            wr_r   <= ~i_wr;
          end
          // A ready drop must pass both samplers before it can be trusted
          3'h1: begin
            tick_r <= tick_r + 4'h1;
            if (tick_r == `IAH_RDY_LAG) step_r <= 3'h2;
          end
          3'h2: if (rdy_r) begin
            o_rdata <= bus.d;
            rd_r    <= 1'b1;
            wr_r    <= 1'b1;
            tick_r  <= 4'h0;
            step_r  <= 3'h3;
          end
          // Data held until the device has seen the strobe rise
          default: begin
            tick_r <= tick_r + 4'h1;
            if (tick_r == `IAH_HOLD_CYC) begin
              doe_r  <= 1'b0;
              act_r  <= 1'b0;
              o_done <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Wait states until a word lines up with a link clock fall; never on I/O
  always_ff @(posedge i_core_clk) begin
    if (i_rst) exrdy_r <= 1'b1;
    else       exrdy_r <= ~(act_r && i_dma && step_r == 3'h0);
  end

  // Narrow mode ties the upper byte enable pins idle; upper data lanes still follow the byte enables
  assign bus.addr                 = addr_r;
  assign bus.io_decode_qualifier  = ~act_r;
  assign bus.async_read_strobe_n  = rd_r;
  assign bus.async_write_strobe_n = wr_r;
  assign bus.byte_lane0_enable_n  = be_r[0];
  assign bus.byte_lane1_enable_n  = be_r[1];
  assign bus.byte_lane2_enable_n  = i_mode32 ? be_r[2] : 1'b1;
  assign bus.byte_lane3_enable_n  = i_mode32 ? be_r[3] : 1'b1;
  assign bus.cycle_qualifier_n    = 1'b1;
  assign bus.write_not_read_dir   = 1'b1;
  assign bus.ready_return_n       = 1'b1;
  assign bus.address_strobe_n     = 1'b0;
  assign bus.local_bus_clock      = i_mode32 ? local_bus_clock_r : 1'b0;
  assign bus.dma_ack_n            = dack_r;
  assign bus.exrdy                = exrdy_r;
  assign bus.host_d_o             = wd_r;
  assign bus.host_d_oe            = {4{doe_r}} & ~be_r;
endmodule
`default_nettype wire

// ---- iah_dev.sv ----
// Purpose: Device end of the asynchronous host slave port
// Assumes: Strobes, link clock, DMA acknowledge and EXRDY are sampled through three flops; user side holds a data register
// Notes:   Ready returns one core edge after user side grants
//
// Behaviour
// - Decode only while qualifier input low
// - Host sets address first; read data during strobe
// - Write data captured at strobe trailing edge
// - Ready dropped at strobe start when delayed
// - Ready back on next clock after grant
// - Low byte enables pick lanes: the two lower in narrow mode, all four in 32-bit mode
// - Unselected lanes float on reads, ignored writes
// - Decode output driven on base match
// - Narrow mode: upper pins held idle
// - EISA strobes built from bus command; code uses only read/write strobes, command pins tied
// - No EISA wait needed on I/O
// - One doubleword per bus clock burst
// - DMA aligned; remainders via I/O
// - Sample EXRDY, hold DMA during waits
`timescale 1ns/1ns
`default_nettype none
`include "iah_map.svh"
module iah_dev
  import iah_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [11:0] i_base,
  input  wire logic        i_mode32,
  input  wire logic        i_grant,
  input  wire logic [31:0] i_rdata,
  output logic             o_busy,
  output logic             o_wr_stb,
  output logic             o_rd_stb,
  output logic [15:1]      o_addr,
  output logic [3:0]       o_lanes,
  output logic [31:0]      o_wdata,
  output logic             o_dma_stb,
  output logic [31:0]      o_dma_data,
  iah_if.dev               bus
);
  logic [2:0]  rd_s_r;
  logic [2:0]  wr_s_r;
  logic [2:0]  local_bus_clock_s_r;
  logic [2:0]  dack_s_r;
  logic        rd_r;
  logic        wr_r;
  logic        local_bus_clock_r;
  logic        dack_r;
  logic        rd_q_r;
  logic        wr_q_r;
  logic        local_bus_clock_q_r;
  logic        rdy_r;
  logic        hit_r;
  logic [31:0] dout_r;
  logic [3:0]  doe_r;
  logic        sel_r;
  iah_state_t  st_r;
  logic [2:0]  exrdy_s_r;
  logic        exrdy_r;
  logic        rd_fall;
  logic        wr_fall;
  logic        dma_take;

  function automatic logic [3:0] lane_sel(input logic [3:0] be_n, input logic m32);
    lane_sel = m32 ? ~be_n : {2'b00, ~be_n[1:0]};
  endfunction

  // Three stage sampling, change taken when last two agree
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rd_s_r   <= 3'h7;
      wr_s_r   <= 3'h7;
      local_bus_clock_s_r <= 3'h0;
      dack_s_r <= 3'h7;
      rd_r     <= 1'b1;
      wr_r     <= 1'b1;
      local_bus_clock_r   <= 1'b0;
      dack_r   <= 1'b1;
      exrdy_s_r <= 3'h7;
      exrdy_r   <= 1'b1;
    end else begin
      rd_s_r   <= {rd_s_r[1:0], bus.async_read_strobe_n};
      wr_s_r   <= {wr_s_r[1:0], bus.async_write_strobe_n};
      local_bus_clock_s_r <= {local_bus_clock_s_r[1:0], bus.local_bus_clock};
      dack_s_r <= {dack_s_r[1:0], bus.dma_ack_n};
      exrdy_s_r <= {exrdy_s_r[1:0], bus.exrdy};
      if (rd_s_r[1] == rd_s_r[2]) rd_r <= rd_s_r[2];
      if (wr_s_r[1] == wr_s_r[2]) wr_r <= wr_s_r[2];
      if (local_bus_clock_s_r[1] == local_bus_clock_s_r[2]) local_bus_clock_r <= local_bus_clock_s_r[2];
      if (dack_s_r[1] == dack_s_r[2]) dack_r <= dack_s_r[2];
      if (exrdy_s_r[1] == exrdy_s_r[2]) exrdy_r <= exrdy_s_r[2];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rd_q_r   <= 1'b1;
      wr_q_r   <= 1'b1;
      local_bus_clock_q_r <= 1'b0;
    end else begin
      rd_q_r   <= rd_r;
      wr_q_r   <= wr_r;
      local_bus_clock_q_r <= local_bus_clock_r;
    end
  end

  // Decode output driven both levels on base match
  always_ff @(posedge i_core_clk) begin
    if (i_rst) hit_r <= 1'b0;
    else       hit_r <= !bus.io_decode_qualifier &&
                        bus.addr[`IAH_ADDR_HI:`IAH_ADDR_LO] == i_base;
  end

  // Edges seen one clock after the sampled strobe settles
  assign rd_fall = !rd_r && rd_q_r;
  assign wr_fall = !wr_r && wr_q_r;

  // Access sequencer with ready handling
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_r     <= IAH_IDLE;
      rdy_r    <= 1'b1;
      sel_r    <= 1'b0;
      o_busy   <= 1'b0;
      o_rd_stb <= 1'b0;
      o_wr_stb <= 1'b0;
      o_addr   <= 15'h0;
      o_lanes  <= 4'h0;
      o_wdata  <= 32'h0;
    end else begin
      o_rd_stb <= 1'b0;
      o_wr_stb <= 1'b0;
      case (st_r)
        IAH_IDLE: begin
          rdy_r <= 1'b1;
          if (rd_fall || wr_fall) begin
            if (hit_r) begin
              o_addr  <= bus.addr;
              o_lanes <= lane_sel({bus.byte_lane3_enable_n, bus.byte_lane2_enable_n,
                                   bus.byte_lane1_enable_n, bus.byte_lane0_enable_n},
                                  i_mode32);
              sel_r   <= 1'b1;
              o_busy  <= 1'b1;
              o_rd_stb <= !rd_r;
              if (!i_grant) begin
                rdy_r <= 1'b0;
                st_r  <= IAH_WAIT;
              end else begin
                st_r  <= IAH_DONE;
              end
            end
          end
        end
        IAH_WAIT: if (i_grant) begin
          rdy_r <= 1'b1;
          st_r  <= IAH_DONE;
        end
        IAH_DONE: begin
          if (rd_r && wr_r) begin
            if (!wr_q_r) begin
              o_wr_stb <= 1'b1;
              o_wdata  <= bus.d;
            end
            sel_r  <= 1'b0;
            o_busy <= 1'b0;
            st_r   <= IAH_IDLE;
          end
        end
        default: st_r <= IAH_IDLE;
      endcase
    end
  end

  // Read data drives only selected lanes during strobe
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      dout_r <= 32'h0;
      doe_r  <= 4'h0;
    end else begin
      dout_r <= i_rdata;
      doe_r  <= (sel_r && !rd_r && rd_q_r == 1'b0) ? o_lanes : 4'h0;
    end
  end

  // Exrdy passes the same depth as the link clock, so word and wait line up
  assign dma_take = i_mode32 && !dack_r && local_bus_clock_r && !local_bus_clock_q_r && exrdy_r;

  // Burst DMA: one word per link clock rise, held while wait states
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_dma_stb  <= 1'b0;
      o_dma_data <= 32'h0;
    end else begin
      o_dma_stb <= 1'b0;
      if (dma_take) begin
        o_dma_stb  <= 1'b1;
        o_dma_data <= bus.d;
      end
    end
  end

  assign bus.async_ready_out    = rdy_r;
  assign bus.local_decode_hit_n = ~hit_r;
  assign bus.dev_d_o            = dout_r;
  assign bus.dev_d_oe           = doe_r;
endmodule
`default_nettype wire

// ---- iah_props.sv ----
// Purpose: Pin checks on the host slave port
// Assumes: Both ends share one iah_if
// Notes:   Settling windows cover the pin synchronisers
`timescale 1ns/1ns
`default_nettype none
module iah_props #(
  parameter logic [11:0] BASE = 12'h030
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic [15:1] addr,
  input wire logic        io_decode_qualifier,
  input wire logic        async_read_strobe_n,
  input wire logic        async_write_strobe_n,
  input wire logic        byte_lane0_enable_n,
  input wire logic        byte_lane1_enable_n,
  input wire logic        async_ready_out,
  input wire logic        local_decode_hit_n,
  input wire logic [3:0]  dev_d_oe
);
  logic base_hit;
  logic idle;
  logic rd_sel;
  assign base_hit = !io_decode_qualifier && (addr[15:4] == BASE);
  assign idle = async_read_strobe_n && async_write_strobe_n;
  assign rd_sel = !async_read_strobe_n && !byte_lane0_enable_n && !local_decode_hit_n;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_decode_hit: assert property (base_hit [*8] |-> !local_decode_hit_n)
    else $error("decode output missed a match");
  chk_decode_miss: assert property ((!base_hit) [*8] |-> local_decode_hit_n)
    else $error("decode output active off a match");
  chk_ready_idle: assert property (idle [*8] |-> async_ready_out)
    else $error("ready low with no access");
  chk_ready_cause: assert property ($fell(async_ready_out) |-> !idle)
    else $error("ready fell outside a strobe");
  chk_ready_bound: assert property ($fell(async_ready_out) |-> ##[1:60] async_ready_out)
    else $error("ready not restored");
  chk_lane0_float: assert property (byte_lane0_enable_n [*6] |-> !dev_d_oe[0])
    else $error("lane 0 driven while unselected");
  chk_lane1_float: assert property (byte_lane1_enable_n [*6] |-> !dev_d_oe[1])
    else $error("lane 1 driven while unselected");
  chk_read_drive: assert property ((rd_sel && async_ready_out) [*8] |-> dev_d_oe[0])
    else $error("read data not driven");
endmodule
`default_nettype wire

// ---- isa_eisa_async_host_slave_tb.sv ----
// Purpose: Self-checking bench, both port ends joined by iah_if
// Assumes: Host end makes the link clock
// Notes:   Waits after each access cover the synchronisers
`timescale 1ns/1ns
`default_nettype none
`include "iah_map.svh"
module isa_eisa_async_host_slave_tb;
  localparam logic [11:0] BASE = `IAH_BASE_RST;
  logic        i_core_clk, i_rst, i_req, i_wr, i_dma, mode32, i_mem_wait, i_grant;
  logic [15:1] i_addr, ca;
  logic [3:0]  i_be_n, cl;
  logic [31:0] i_wdata, i_rdata, cw, cd, r;
  wire logic        h_done, h_hit, d_busy, d_wr, d_rd, d_dstb;
  wire logic [31:0] h_rdata, d_wdata, d_ddata;
  wire logic [15:1] d_addr;
  wire logic [3:0]  d_lanes;
  int          errors, tests_run, seed, grant_dly, gcnt, wcnt, rcnt, dcnt;
  logic [3:0]  be16 [3] = '{4'hc, 4'he, 4'hd};
  logic [3:0]  be32 [7] = '{4'h0, 4'hc, 4'h3, 4'he, 4'hd, 4'hb, 4'h7};
  iah_if bus_if ();
  iah_host iah_host_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(i_req), .i_wr(i_wr),
    .i_mode32(mode32), .i_dma(i_dma), .i_addr(i_addr), .i_be_n(i_be_n), .i_wdata(i_wdata),
    .i_mem_wait(i_mem_wait), .o_done(h_done), .o_rdata(h_rdata), .o_hit(h_hit), .bus(bus_if));
  iah_dev iah_dev_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_base(BASE),
    .i_mode32(mode32), .i_grant(i_grant), .i_rdata(i_rdata), .o_busy(d_busy), .o_wr_stb(d_wr),
    .o_rd_stb(d_rd), .o_addr(d_addr), .o_lanes(d_lanes), .o_wdata(d_wdata),
    .o_dma_stb(d_dstb), .o_dma_data(d_ddata), .bus(bus_if));
  iah_props #(.BASE(BASE)) iah_props_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .addr(bus_if.addr), .io_decode_qualifier(bus_if.io_decode_qualifier),
    .async_read_strobe_n(bus_if.async_read_strobe_n),
    .async_write_strobe_n(bus_if.async_write_strobe_n),
    .byte_lane0_enable_n(bus_if.byte_lane0_enable_n),
    .byte_lane1_enable_n(bus_if.byte_lane1_enable_n),
    .async_ready_out(bus_if.async_ready_out), .local_decode_hit_n(bus_if.local_decode_hit_n),
    .dev_d_oe(bus_if.dev_d_oe));
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  // Grant seen by the device grant_dly+1 cycles after busy; zero means no delay at all
  always @(negedge i_core_clk) begin
    gcnt = d_busy ? gcnt + 1 : 0;
    i_grant = (grant_dly == 0) || (gcnt > grant_dly);
    if (d_wr) begin
      wcnt++;
      cw = d_wdata;
      ca = d_addr;
      cl = d_lanes;
    end
    if (d_rd) rcnt++;
    if (d_dstb) begin
      dcnt++;
      cd = d_ddata;
    end
  end
  task automatic end_sim();
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [3:0] exp_lanes(input logic [3:0] be);
    return ~be & (mode32 ? 4'hf : 4'h3);
  endfunction
  function automatic logic [31:0] lane_mask(input logic [3:0] ln);
    return {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
  endfunction
  task automatic xfer(input logic wr, input logic dma, input logic [15:1] a,
                      input logic [3:0] be, input int gd, input int stall);
    int          n, w0, r0, d0;
    logic [3:0]  ln;
    logic [31:0] m, wd;
    logic        hit;
    wd = $random(seed);
    ln = exp_lanes(be);
    m = lane_mask(ln);
    hit = (a[15:4] == BASE);
    w0 = wcnt;
    r0 = rcnt;
    d0 = dcnt;
    @(negedge i_core_clk);
    i_wr = wr;
    i_dma = dma;
    i_addr = a;
    i_be_n = be;
    i_wdata = wd;
    i_rdata = ~wd;
    grant_dly = gd;
    i_mem_wait = (stall > 0);
    i_req = 1'b1;
    repeat (stall) @(negedge i_core_clk);
    if (stall > 0) chk(dcnt, d0);
    i_mem_wait = 1'b0;
    for (n = 0; n < 500 && h_done !== 1'b1; n++) @(negedge i_core_clk);
    if (h_done !== 1'b1) begin
      errors++;
      end_sim();
    end
    chk(h_hit, hit);
    if (!wr && !dma && hit) chk(h_rdata & m, ~wd & m);
    i_req = 1'b0;
    repeat (8) @(negedge i_core_clk);
    if (dma) begin
      chk(dcnt, d0 + 1);
      chk(cd, wd);
    end else if (!hit) chk(wcnt + rcnt, w0 + r0);
    else if (!wr) chk(rcnt, r0 + 1);
    else begin
      chk(wcnt, w0 + 1);
      chk(cw & m, wd & m);
      chk(cl, ln);
      chk(ca, a);
    end
  endtask
  initial begin
    {errors, tests_run, wcnt, rcnt, dcnt, grant_dly, gcnt} = '0;
    seed = 4078;
    {i_rst, i_req, i_wr, i_dma, mode32, i_mem_wait, i_grant} = 7'h41;
    i_addr = 15'h0;
    i_be_n = 4'hf;
    i_wdata = 32'h0;
    i_rdata = 32'h0;
    repeat (4) @(negedge i_core_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_core_clk);
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, 1'b0, {BASE, 3'h1}, be16[k], 0, 0);
      xfer(1'b0, 1'b0, {BASE, 3'h2}, be16[k], 3, 0);
    end
    xfer(1'b1, 1'b0, {BASE + 12'h001, 3'h0}, 4'hc, 0, 0);
    mode32 = 1'b1;
    for (int k = 0; k < 7; k++) begin
      xfer(1'b1, 1'b0, {BASE, 3'h3}, be32[k], k, 0);
      xfer(1'b0, 1'b0, {BASE, 3'h4}, be32[k], 6 - k, 0);
    end
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      xfer(r[0], 1'b0, {r[1] ? BASE : BASE ^ 12'h800, r[4:2]}, be32[r[7:5] % 7], r[10:8], 0);
    end
    xfer(1'b1, 1'b1, {BASE, 3'h0}, 4'h0, 0, 40);
    xfer(1'b1, 1'b1, {BASE, 3'h0}, 4'h0, 0, 0);
    end_sim();
  end
endmodule
`default_nettype wire
